// File: hdl/iowhd_sync.sv
// two-flop synchroniser for every pin level read by the decoder
module iowhd_sync
   import iowhd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [iowhd_pkg::HB_ADDR_W-1:0] addr_in,
   input wire logic aen_in,
   input wire logic ior_n_in,
   input wire logic iow_n_in,
   input wire logic [iowhd_pkg::HB_DATA_W-1:0] wdata_in,
   input wire logic [iowhd_pkg::HB_DATA_W-1:0] ctrl_rdata_in,
   input wire logic ctrl_irq_in,
   input wire logic [iowhd_pkg::HB_DATA_W-1:0] sw_in,
   input wire logic [iowhd_pkg::BASE_SEL_W-1:0] base_sel_in,
   input wire logic [iowhd_pkg::IRQ_LINES-1:0] irq_sel_in,
   iowhd_sync_if.src sync_out
);
   localparam int SW = HB_ADDR_W + 3 + 3 * HB_DATA_W + 1 + BASE_SEL_W + IRQ_LINES;
   // strobes idle high so reset leaves the bus looking inactive
   localparam logic [SW-1:0] SYNC_RST = {{HB_ADDR_W{1'b0}}, 3'h7, {(SW - HB_ADDR_W - 3){1'b0}}};

   logic [SW-1:0] raw;
   logic [SW-1:0] meta_r;
   logic [SW-1:0] stable_r;

   assign raw = {addr_in, aen_in, ior_n_in, iow_n_in, wdata_in, ctrl_rdata_in, ctrl_irq_in, sw_in,
                 base_sel_in, irq_sel_in};

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         meta_r <= SYNC_RST;
         stable_r <= SYNC_RST;
      end else begin
         meta_r <= raw;
         stable_r <= meta_r;
      end
   end

   assign {sync_out.addr, sync_out.aen, sync_out.ior_n, sync_out.iow_n, sync_out.wdata, sync_out.ctrl_rdata,
           sync_out.ctrl_irq, sync_out.sw, sync_out.base_sel, sync_out.irq_sel} = stable_r;
endmodule

// File: hdl/iowhd_top.sv
// host i/o window decode: address match, register routing, switch port and interrupt steering
// Summary of operation
// - decode exactly sixteen consecutive host i/o locations as the register window
// - window base sits on a sixteen-byte boundary; a3..a0 pick the location
// - a9..a4 compared against base jumpers; bases 0x100 to 0x3f0 only
// - respond only to host i/o cycles, never to memory space
// - reserved locations have no function; host must not map other peripherals there
// - every access completes without wait states or bus arbitration
// - controller interrupt drives exactly one selected host irq line at most
// - no irq jumper fitted means no host irq line is driven
// - switch port returns eight bits, position one is msb, open reads one
// - switch port is independent; reading it never touches the controller
module iowhd_top
   import iowhd_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [iowhd_pkg::HB_ADDR_W-1:0] sa_in,
   input wire logic aen_in,
   input wire logic ior_n_in,
   input wire logic iow_n_in,
   input wire logic [iowhd_pkg::HB_DATA_W-1:0] sd_in,
   output logic [iowhd_pkg::HB_DATA_W-1:0] sd_out,
   output logic sd_oe_out,
   input wire logic [iowhd_pkg::BASE_SEL_W-1:0] base_select_jumpers_in,
   input wire logic [iowhd_pkg::IRQ_LINES-1:0] irq_select_jumpers_in,
   input wire logic [iowhd_pkg::HB_DATA_W-1:0] switch_bank_in,
   output logic [iowhd_pkg::IRQ_LINES-1:0] irq_out,
   output logic [iowhd_pkg::IRQ_LINES-1:0] irq_oe_out,
   output logic ctrl_cs_n_out,
   output logic ctrl_rd_n_out,
   output logic ctrl_wr_n_out,
   output logic [2:0] ctrl_addr_out,
   input wire logic [iowhd_pkg::HB_DATA_W-1:0] ctrl_data_in,
   output logic [iowhd_pkg::HB_DATA_W-1:0] ctrl_data_out,
   output logic ctrl_data_oe_out,
   input wire logic ctrl_irq_in
);
   import iowhd_pkg::*;

   function automatic logic [IRQ_LINES-1:0] iowhd_first_line(input logic [IRQ_LINES-1:0] sel);
      return sel & (~sel + 11'h001);
   endfunction

   function automatic logic iowhd_off_ctrl(input logic [WIN_OFF_W-1:0] off);
      return off <= OFF_TENTATIVE_OR_SUCCESSOR_ID;
   endfunction

   function automatic logic iowhd_off_sw(input logic [WIN_OFF_W-1:0] off);
      return (off == OFF_SWITCH_INPUT_PORT) || (off == OFF_SWITCH_INPUT_PORT_ALIAS);
   endfunction

   iowhd_sync_if sy ();

   iowhd_sync u_sync (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .addr_in(sa_in),
      .aen_in(aen_in),
      .ior_n_in(ior_n_in),
      .iow_n_in(iow_n_in),
      .wdata_in(sd_in),
      .ctrl_rdata_in(ctrl_data_in),
      .ctrl_irq_in(ctrl_irq_in),
      .sw_in(switch_bank_in),
      .base_sel_in(base_select_jumpers_in),
      .irq_sel_in(irq_select_jumpers_in),
      .sync_out(sy)
   );

   iowhd_state_t st_r;
   iowhd_state_t st_nxt;
   logic [HB_DATA_W-1:0] sd_r;
   logic sd_oe_r;
   logic cs_n_r;
   logic rd_n_r;
   logic wr_n_r;
   logic [2:0] caddr_r;
   logic [HB_DATA_W-1:0] cdata_r;
   logic coe_r;
   logic [IRQ_LINES-1:0] irq_r;
   logic [IRQ_LINES-1:0] irq_oe_r;

   // memory cycles keep aen low too, so only ior/iow qualify a hit
   wire host_rd = !sy.aen && !sy.ior_n && sy.iow_n;
   wire host_wr = !sy.aen && !sy.iow_n && sy.ior_n;
   wire base_ok = sy.base_sel >= BASE_SEL_MIN;
   wire win_hit = base_ok && (sy.addr[HB_ADDR_W-1:WIN_OFF_W] == sy.base_sel);
   wire [WIN_OFF_W-1:0] win_off = sy.addr[WIN_OFF_W-1:0];
   wire off_ctrl = iowhd_off_ctrl(win_off);
   wire off_sw = iowhd_off_sw(win_off);
   // offsets a..f fall through both tests and are left undriven
   wire rd_go = host_rd && win_hit && (off_ctrl || off_sw);
   wire wr_go = host_wr && win_hit && off_ctrl;
   wire [IRQ_LINES-1:0] irq_pick = iowhd_first_line(sy.irq_sel);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         CYC_IDLE: begin
            if (rd_go) begin
               st_nxt = CYC_READ;
            end else if (wr_go) begin
               st_nxt = CYC_WRITE;
            end
         end
         CYC_READ: begin
            if (!rd_go) begin
               st_nxt = CYC_IDLE;
            end
         end
         CYC_WRITE: begin
            if (!wr_go) begin
               st_nxt = CYC_IDLE;
            end
         end
         default: begin
            st_nxt = CYC_IDLE;
         end
      endcase
   end

   // no ready line is ever pulled: the host strobe alone frames each access
   wire nxt_rd = st_nxt == CYC_READ;
   wire nxt_wr = st_nxt == CYC_WRITE;
   wire nxt_ctrl = (nxt_rd && off_ctrl) || nxt_wr;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= CYC_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cs_n_r <= 1'b1;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         caddr_r <= CTRL_ADDR_RST;
         cdata_r <= DATA_RST;
         coe_r <= 1'b0;
      end else begin
         cs_n_r <= !nxt_ctrl;
         rd_n_r <= !(nxt_rd && off_ctrl);
         wr_n_r <= !nxt_wr;
         caddr_r <= win_off[2:0];
         cdata_r <= sy.wdata;
         coe_r <= nxt_wr;
      end
   end

   // switch levels pass straight: bit 7 is position one, an open contact is high
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sd_r <= DATA_RST;
         sd_oe_r <= 1'b0;
      end else begin
         sd_r <= off_sw ? sy.sw : sy.ctrl_rdata;
         sd_oe_r <= nxt_rd;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_r <= IRQ_RST;
         irq_oe_r <= IRQ_RST;
      end else begin
         irq_r <= irq_pick & {IRQ_LINES{sy.ctrl_irq}};
         irq_oe_r <= irq_pick;
      end
   end

   assign sd_out = sd_r;
   assign sd_oe_out = sd_oe_r;
   assign ctrl_cs_n_out = cs_n_r;
   assign ctrl_rd_n_out = rd_n_r;
   assign ctrl_wr_n_out = wr_n_r;
   assign ctrl_addr_out = caddr_r;
   assign ctrl_data_out = cdata_r;
   assign ctrl_data_oe_out = coe_r;
   assign irq_out = irq_r;
   assign irq_oe_out = irq_oe_r;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);

   property p_cs_only_in_window;
      $fell(cs_n_r) |-> $past(win_hit && off_ctrl && (host_rd || host_wr));
   endproperty
   a_cs_only_in_window: assert property (p_cs_only_in_window) else $error("controller select outside window");

   property p_read_aligned;
      $rose(sd_oe_r) |-> $past(sy.addr[HB_ADDR_W-1:WIN_OFF_W] == sy.base_sel);
   endproperty
   a_read_aligned: assert property (p_read_aligned) else $error("read answered off the base block");

   property p_low_base_ignored;
      (st_r == CYC_IDLE && sy.base_sel < BASE_SEL_MIN) |=> (cs_n_r && !sd_oe_r);
   endproperty
   a_low_base_ignored: assert property (p_low_base_ignored) else $error("base below 0x100 decoded");

   property p_aen_blocks;
      (st_r == CYC_IDLE && sy.aen) |=> (st_r == CYC_IDLE) [*2];
   endproperty
   a_aen_blocks: assert property (p_aen_blocks) else $error("cycle taken with aen high");

   property p_reserved_quiet;
      (st_r == CYC_IDLE && win_hit && win_off > OFF_SWITCH_INPUT_PORT_ALIAS) |=> (cs_n_r && !sd_oe_r);
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved offset answered");

   property p_read_no_wait;
      (st_r == CYC_IDLE && rd_go) |=> (sd_oe_r && st_r == CYC_READ);
   endproperty
   a_read_no_wait: assert property (p_read_no_wait) else $error("read not answered next cycle");

   property p_one_irq;
      $onehot0(irq_oe_r) && ((irq_r & ~irq_oe_r) == IRQ_RST);
   endproperty
   a_one_irq: assert property (p_one_irq) else $error("more than one irq line driven");

   property p_no_irq_sel;
      (sy.irq_sel == IRQ_RST) |=> (irq_oe_r == IRQ_RST);
   endproperty
   a_no_irq_sel: assert property (p_no_irq_sel) else $error("irq driven with no jumper");

   property p_switch_value;
      (rd_go && off_sw) |=> (sd_r == $past(sy.sw));
   endproperty
   a_switch_value: assert property (p_switch_value) else $error("switch port value wrong");

   property p_switch_isolated;
      (st_r == CYC_IDLE && rd_go && off_sw) |=> (cs_n_r && rd_n_r && wr_n_r);
   endproperty
   a_switch_isolated: assert property (p_switch_isolated) else $error("switch read touched controller");

   property p_write_route;
      (st_r == CYC_IDLE && wr_go) |=> (!cs_n_r && !wr_n_r && rd_n_r && caddr_r == $past(win_off[2:0]));
   endproperty
   a_write_route: assert property (p_write_route) else $error("write not routed to controller");

   property p_rd_wr_split;
      !(!rd_n_r && !wr_n_r) && (coe_r == !wr_n_r);
   endproperty
   a_rd_wr_split: assert property (p_rd_wr_split) else $error("read and write strobes overlap");

   c_ctrl_read: cover property (st_r == CYC_READ && !rd_n_r);
   c_ctrl_write: cover property (st_r == CYC_WRITE && !wr_n_r);
   c_switch_read: cover property (st_r == CYC_READ && cs_n_r && sd_oe_r);
   c_irq_routed: cover property (irq_oe_r != IRQ_RST && irq_r != IRQ_RST);
endmodule

// File: shared/iowhd_pkg.sv
// constants and types shared by the host i/o window decode design
package iowhd_pkg;
   localparam int HB_ADDR_W = 10;
   localparam int HB_DATA_W = 8;
   localparam int BASE_SEL_W = 6;
   localparam int IRQ_LINES = 11;
   localparam int WIN_OFF_W = 4;
   localparam int WIN_SIZE = 16;
   localparam int CLK_PERIOD_NS = 50;
   localparam int SYNC_STAGES = 2;
   // lowest selectable base 0x100 seen on a9..a4
   localparam logic [BASE_SEL_W-1:0] BASE_SEL_MIN = 6'h10;
   // window offsets of the controller registers, the switch port and its alias, and the last reserved location
   localparam logic [WIN_OFF_W-1:0] OFF_STATUS_READ_IRQ_MASK_WRITE = 4'h0;
   localparam logic [WIN_OFF_W-1:0] OFF_DIAG_STATUS_READ_COMMAND_WRITE = 4'h1;
   localparam logic [WIN_OFF_W-1:0] OFF_RAM_POINTER_HIGH = 4'h2;
   localparam logic [WIN_OFF_W-1:0] OFF_RAM_POINTER_LOW = 4'h3;
   localparam logic [WIN_OFF_W-1:0] OFF_RAM_DATA_PORT = 4'h4;
   localparam logic [WIN_OFF_W-1:0] OFF_SECONDARY_INDEX = 4'h5;
   localparam logic [WIN_OFF_W-1:0] OFF_CONFIGURATION = 4'h6;
   localparam logic [WIN_OFF_W-1:0] OFF_TENTATIVE_OR_SUCCESSOR_ID = 4'h7;
   localparam logic [WIN_OFF_W-1:0] OFF_SWITCH_INPUT_PORT = 4'h8;
   localparam logic [WIN_OFF_W-1:0] OFF_SWITCH_INPUT_PORT_ALIAS = 4'h9;
   localparam logic [WIN_OFF_W-1:0] OFF_RESERVED_LAST = 4'hf;
   // reset values of registered outputs
   localparam logic [HB_DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [2:0] CTRL_ADDR_RST = 3'h0;
   localparam logic [IRQ_LINES-1:0] IRQ_RST = 11'h000;
   // host cycle tracker, gray along idle-read-idle and idle-write-idle
   typedef enum logic [1:0] {
      CYC_IDLE = 2'b00,
      CYC_READ = 2'b01,
      CYC_WRITE = 2'b10
   } iowhd_state_t;
endpackage

// File: shared/iowhd_sync_if.sv
// synchronised pin levels handed from the input stage to the decoder
interface iowhd_sync_if;
   import iowhd_pkg::*;
   logic [HB_ADDR_W-1:0] addr;
   logic aen;
   logic ior_n;
   logic iow_n;
   logic [HB_DATA_W-1:0] wdata;
   logic [HB_DATA_W-1:0] ctrl_rdata;
   logic ctrl_irq;
   logic [HB_DATA_W-1:0] sw;
   logic [BASE_SEL_W-1:0] base_sel;
   logic [IRQ_LINES-1:0] irq_sel;
   modport src (output addr, aen, ior_n, iow_n, wdata, ctrl_rdata, ctrl_irq, sw, base_sel, irq_sel);
   modport dst (input addr, aen, ior_n, iow_n, wdata, ctrl_rdata, ctrl_irq, sw, base_sel, irq_sel);
endinterface

// File: verification/io_window_host_decode_tb.sv
// self-checking bench for the host i/o window decode block
module io_window_host_decode_tb import iowhd_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in, rst_in, aen, ior_n, iow_n, sd_oe, cs_n, rd_n, wr_n, cdoe, cirq, clr;
   logic [9:0] sa;
   logic [7:0] sd_w, sd_r, sw, cdata_in, cdata_out, wd_seen;
   logic [5:0] base_sel;
   logic [10:0] irq_sel, irq, irq_oe;
   logic [2:0] caddr, addr_seen;
   logic rd_seen, wr_seen, doe_seen;
   int cs_cnt = 0;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   iowhd_host_model host (.clk_in(clk_in), .sa_out(sa), .aen_out(aen), .ior_n_out(ior_n), .iow_n_out(iow_n),
      .sd_out(sd_w), .sd_in(sd_r), .sd_oe_in(sd_oe));
   iowhd_top uut (.clk_in(clk_in), .rst_in(rst_in), .sa_in(sa), .aen_in(aen), .ior_n_in(ior_n), .iow_n_in(iow_n),
      .sd_in(sd_w), .sd_out(sd_r), .sd_oe_out(sd_oe), .base_select_jumpers_in(base_sel),
      .irq_select_jumpers_in(irq_sel), .switch_bank_in(sw), .irq_out(irq), .irq_oe_out(irq_oe),
      .ctrl_cs_n_out(cs_n), .ctrl_rd_n_out(rd_n), .ctrl_wr_n_out(wr_n), .ctrl_addr_out(caddr),
      .ctrl_data_in(cdata_in), .ctrl_data_out(cdata_out), .ctrl_data_oe_out(cdoe), .ctrl_irq_in(cirq));
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // remembers what the controller saw while it was selected
   always @(posedge clk_in) begin
      if (clr) begin
         cs_cnt <= 0;
      end else if (cs_n === 1'b0) begin
         cs_cnt <= cs_cnt + 1;
         addr_seen <= caddr;
         rd_seen <= rd_n;
         wr_seen <= wr_n;
         doe_seen <= cdoe;
         wd_seen <= cdata_out;
      end
   end
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic wr, input logic aen_v, input logic [9:0] a, input logic [7:0] d,
                      input logic hit, input logic ctl, input logic [7:0] exp_rd);
      logic [7:0] rd;
      logic oe;
      clr <= 1'b1;
      @(posedge clk_in);
      clr <= 1'b0;
      host.io_cycle(wr, aen_v, a, d, rd, oe);
      chk("sd_oe_out", 16'(!wr && hit), 16'(oe));
      if (!wr && hit) chk("sd_out", 16'(exp_rd), 16'(rd));
      chk("ctrl_cs_n_out active", 16'(ctl), 16'(cs_cnt != 0));
      if (ctl) begin
         chk("ctrl_addr_out", 16'(a[2:0]), 16'(addr_seen));
         chk("ctrl_rd_n_out", 16'(wr), 16'(rd_seen));
         chk("ctrl_wr_n_out", 16'(!wr), 16'(wr_seen));
         chk("ctrl_data_oe_out", 16'(wr), 16'(doe_seen));
         if (wr) chk("ctrl_data_out", 16'(d), 16'(wd_seen));
      end
   endtask
   task automatic t_reset();
      chk("sd_oe_out", 16'h0000, 16'(sd_oe));
      chk("irq_oe_out", 16'h0000, 16'(irq_oe));
      chk("ctrl_cs_n_out", 16'h0001, 16'(cs_n));
      chk("ctrl_data_oe_out", 16'h0000, 16'(cdoe));
   endtask
   task automatic t_ctrl_regs();
      for (int off = 0; off < 8; off++) begin
         cdata_in <= 8'hc0 | 8'(off);
         acc(1'b0, 1'b0, {base_sel, 4'(off)}, 8'h00, 1'b1, 1'b1, 8'hc0 | 8'(off));
         acc(1'b1, 1'b0, {base_sel, 4'(off)}, 8'h30 + 8'(off), 1'b1, 1'b1, 8'h00);
      end
   endtask
   task automatic t_switch();
      sw <= 8'hf5;
      acc(1'b0, 1'b0, {base_sel, 4'h8}, 8'h00, 1'b1, 1'b0, 8'hf5);
      sw <= 8'h0a;
      acc(1'b0, 1'b0, {base_sel, 4'h9}, 8'h00, 1'b1, 1'b0, 8'h0a);
      acc(1'b1, 1'b0, {base_sel, 4'h8}, 8'h77, 1'b0, 1'b0, 8'h00);
   endtask
   task automatic t_refused();
      for (int off = 10; off < 16; off++) begin
         acc(1'b0, 1'b0, {base_sel, 4'(off)}, 8'h00, 1'b0, 1'b0, 8'h00);
         acc(1'b1, 1'b0, {base_sel, 4'(off)}, 8'h5c, 1'b0, 1'b0, 8'h00);
      end
      acc(1'b0, 1'b1, {base_sel, 4'h0}, 8'h00, 1'b0, 1'b0, 8'h00);
      acc(1'b1, 1'b1, {base_sel, 4'h2}, 8'h11, 1'b0, 1'b0, 8'h00);
      acc(1'b0, 1'b0, {base_sel ^ 6'h01, 4'h0}, 8'h00, 1'b0, 1'b0, 8'h00);
      acc(1'b0, 1'b0, {base_sel ^ 6'h20, 4'h3}, 8'h00, 1'b0, 1'b0, 8'h00);
   endtask
   task automatic t_bases();
      base_sel <= 6'h10;
      repeat (3) @(posedge clk_in);
      acc(1'b0, 1'b0, 10'h100, 8'h00, 1'b1, 1'b1, cdata_in);
      acc(1'b0, 1'b0, 10'h110, 8'h00, 1'b0, 1'b0, 8'h00);
      base_sel <= 6'h3f;
      repeat (3) @(posedge clk_in);
      acc(1'b1, 1'b0, 10'h3f7, 8'h9e, 1'b1, 1'b1, 8'h00);
      acc(1'b0, 1'b0, 10'h3e7, 8'h00, 1'b0, 1'b0, 8'h00);
      base_sel <= 6'h0f;
      repeat (3) @(posedge clk_in);
      acc(1'b0, 1'b0, 10'h0f0, 8'h00, 1'b0, 1'b0, 8'h00);
   endtask
   task automatic t_irq();
      for (int i = 0; i < 11; i++) begin
         irq_sel <= 11'h001 << i;
         cirq <= 1'b1;
         repeat (4) @(posedge clk_in);
         chk("irq_oe_out", 16'(11'h001 << i), 16'(irq_oe));
         chk("irq_out asserted", 16'(11'h001 << i), 16'(irq & irq_oe));
         cirq <= 1'b0;
         repeat (4) @(posedge clk_in);
         chk("irq_out released", 16'h0000, 16'(irq & irq_oe));
      end
      irq_sel <= 11'h028;
      repeat (4) @(posedge clk_in);
      chk("irq_oe_out two fitted", 16'h0008, 16'(irq_oe));
      irq_sel <= 11'h000;
      cirq <= 1'b1;
      repeat (4) @(posedge clk_in);
      chk("irq_oe_out none fitted", 16'h0000, 16'(irq_oe));
   endtask
   initial begin
      rst_in = 1'b1;
      clr = 1'b0;
      base_sel = 6'h2a;
      irq_sel = 11'h000;
      sw = 8'hff;
      cdata_in = 8'h00;
      cirq = 1'b0;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      t_reset();
      t_ctrl_regs();
      t_switch();
      t_refused();
      t_bases();
      t_irq();
      end_of_test();
   end
endmodule

// File: verification/iowhd_host_model.sv
// host processor model: drives plain i/o read and write cycles on the host bus
module iowhd_host_model (
   input wire logic clk_in,
   output logic [9:0] sa_out,
   output logic aen_out,
   output logic ior_n_out,
   output logic iow_n_out,
   output logic [7:0] sd_out,
   input wire logic [7:0] sd_in,
   input wire logic sd_oe_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // fixed strobe length: the bus has no ready line, so the host never stretches a cycle
   localparam int STROBE_CYC = 6;
   initial begin
      sa_out = 10'h000;
      aen_out = 1'b0;
      ior_n_out = 1'b1;
      iow_n_out = 1'b1;
      sd_out = 8'h5a;
   end
   task automatic io_cycle(input logic wr, input logic aen, input logic [9:0] addr, input logic [7:0] wdata,
                           output logic [7:0] rdata, output logic oe);
      @(posedge clk_in);
      sa_out <= addr;
      aen_out <= aen;
      if (wr) begin
         iow_n_out <= 1'b0;
         sd_out <= wdata;
      end else begin
         ior_n_out <= 1'b0;
      end
      repeat (STROBE_CYC - 1) @(posedge clk_in);
      rdata = sd_in;
      oe = sd_oe_in;
      ior_n_out <= 1'b1;
      iow_n_out <= 1'b1;
      // released data lines: show the inverse so stale data never looks valid
      sd_out <= ~sd_out;
      aen_out <= 1'b0;
      repeat (4) @(posedge clk_in);
   endtask
endmodule
